// *** five_class_cfg.svh ***
`ifndef FIVE_CLASS_CFG_SVH
`define FIVE_CLASS_CFG_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define OFS_SP_LOW          8'h00
`define OFS_SP_LOW_APPR     8'h04
`define OFS_SP_HIGH_APPR    8'h08
`define OFS_SP_HIGH         8'h0C
`define OFS_STATUS          8'h10

// ****************************************************************
// Status field positions.
// ****************************************************************
`define ST_PRESENT_LSB      0
`define ST_SHOWN_LSB        4
`define ST_ACTIVE_BIT       8
`define ST_MODE_LSB         12
`define ST_SELECT_LSB       16

// ****************************************************************
// Setpoint reset values, ascending from low to high.
// ****************************************************************
`define RST_SP_LOW          32'h0000_1000
`define RST_SP_LOW_APPR     32'h0000_3000
`define RST_SP_HIGH_APPR    32'h0000_5000
`define RST_SP_HIGH         32'h0000_7000

`endif

// *** five_class_pkg.sv ***
package five_class_pkg;

    // ****************************************************************
    // Front selector positions as coded on the selector pins.
    // ****************************************************************
    typedef enum logic [2:0] {
        SEL_CAL_LOW       = 3'h0,
        SEL_CAL_LOW_APPR  = 3'h1,
        SEL_CAL_HIGH_APPR = 3'h2,
        SEL_CAL_HIGH      = 3'h3,
        SEL_MANUAL_RUN    = 3'h4,
        SEL_AUTO_RUN      = 3'h5
    } selector_type;

    // ****************************************************************
    // Operating modes.
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_FOLLOW = 2'h0,
        MODE_LATCH  = 2'h1,
        MODE_HOLD   = 2'h2,
        MODE_RESET  = 2'h3
    } mode_type;

    // ****************************************************************
    // Classes in ascending order of the measurement.
    // ****************************************************************
    typedef enum logic [2:0] {
        CLS_UNDER      = 3'h0,
        CLS_UNDER_APPR = 3'h1,
        CLS_GOOD       = 3'h2,
        CLS_OVER_APPR  = 3'h3,
        CLS_OVER       = 3'h4
    } class_type;

endpackage

// *** bit_sync.sv ***
`timescale 1ns/10ps

module bit_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             CLK_SYS,
    input  wire logic             RST_N,
    // Data.
    input  wire logic [WIDTH-1:0] ASYNC_IN,
    output logic      [WIDTH-1:0] SYNC_OUT
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            meta_q   <= '0;
            SYNC_OUT <= '0;
        end else begin
            meta_q   <= ASYNC_IN;
            SYNC_OUT <= meta_q;
        end
    end

endmodule // bit_sync

// *** five_class_limit.sv ***
`timescale 1ns/10ps
`include "five_class_cfg.svh"

// Operation
// RL1 - The selector offers four calibration positions, manual run and automatic run.
// RL2 - In a calibration position the display path shows the setpoint of that position.
// RL3 - In manual run the class outputs track the present class and the command lines are ignored.
// RL4 - The command lines act only while the selector stands at automatic run.
// RL5 - The two command lines together select reset, follow, latch or hold.
// RL6 - Reset clears the stored extreme and turns all lamps and class outputs off.
// RL7 - Follow behaves as manual run, tracking the present class.
// RL8 - Latch keeps the most extreme class reached, cleared only by reset or follow.
// RL9 - Hold freezes lamps and class outputs until reset or follow is entered; the code also leaves hold when latch is entered.
// RL10 - Both lines off is follow, clear only is latch, both on is hold, freeze only is reset.
// RL11 - The measurement is sorted into five classes by four ordered setpoints.
// RL12 - Class outputs over, good, under read 001, 011, 010, 110, 100 from under to over.
// RL13 - Command lines and selector pass a two-flop synchroniser before decoding.
module five_class_limit #(
    parameter int MEAS_W = 16
) (
    // Clock and reset.
    input  wire logic                         CLK_SYS,
    input  wire logic                         RST_N,
    // Wishbone slave.
    input  wire logic                         WB_CYC_I,
    input  wire logic                         WB_STB_I,
    input  wire logic                         WB_WE_I,
    input  wire logic [7:0]                   WB_ADR_I,
    input  wire logic [3:0]                   WB_SEL_I,
    input  wire logic [31:0]                  WB_DAT_I,
    output logic      [31:0]                  WB_DAT_O,
    output logic                              WB_ACK_O,
    // Front selector and rear command lines.
    input  wire logic [2:0]                   SELECTOR,
    input  wire logic                         FREEZE_COMMAND_LINE,
    input  wire logic                         CLEAR_COMMAND_LINE,
    // Measurement and display path.
    input  wire logic [MEAS_W-1:0]            MEASUREMENT,
    output logic      [MEAS_W-1:0]            DISPLAY_VALUE,
    // Lamps, one per class, and encoded class outputs.
    output logic      [4:0]                   LIMIT_LAMPS,
    output logic                              OVER_CLASS_OUTPUT,
    output logic                              GOOD_CLASS_OUTPUT,
    output logic                              UNDER_CLASS_OUTPUT
);
    import five_class_pkg::*;

    // ****************************************************************
    // Parameter check.
    // ****************************************************************
    generate
        if (MEAS_W < 1 || MEAS_W > 32) begin : g_bad_width
            $error("MEAS_W must lie between 1 and 32");
        end
    endgenerate

    // ****************************************************************
    // Functions.
    // ****************************************************************
    function automatic logic [2:0] class_code(input class_type c);
        unique case (c)
            CLS_UNDER:      class_code = 3'h1;
            CLS_UNDER_APPR: class_code = 3'h3;
            CLS_GOOD:       class_code = 3'h2;
            CLS_OVER_APPR:  class_code = 3'h6;
            CLS_OVER:       class_code = 3'h4;
            default:        class_code = 3'h0;
        endcase
    endfunction

    function automatic logic [1:0] distance(input class_type c);
        distance = (c >= CLS_GOOD) ? 2'(c - CLS_GOOD) : 2'(CLS_GOOD - c);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        merge = r;
    endfunction

    // ****************************************************************
    // Synchronisers.
    // ****************************************************************
    logic [4:0] pins_s;

    bit_sync #(
        .WIDTH    (5)
    ) u_sync (
        .CLK_SYS  (CLK_SYS),
        .RST_N    (RST_N),
        .ASYNC_IN ({SELECTOR, FREEZE_COMMAND_LINE, CLEAR_COMMAND_LINE}),  // [RL13]
        .SYNC_OUT (pins_s)
    );

    // ****************************************************************
    // Mode decode.
    // ****************************************************************
    selector_type sel_pos;
    logic         is_cal;
    logic         is_auto;
    mode_type     remote_mode;
    mode_type     mode;

    // Codes 6 and 7 cannot come from a six-position switch; they fall back to manual run.
    assign sel_pos     = (pins_s[4:2] > 3'h5) ? SEL_MANUAL_RUN : selector_type'(pins_s[4:2]);  // [RL1]
    assign is_cal      = (sel_pos <= SEL_CAL_HIGH);
    assign is_auto     = (sel_pos == SEL_AUTO_RUN);
    assign remote_mode = pins_s[1] ? (pins_s[0] ? MODE_HOLD : MODE_RESET)
                                   : (pins_s[0] ? MODE_LATCH : MODE_FOLLOW);  // [RL5] [RL10]
    assign mode        = is_auto ? remote_mode : MODE_FOLLOW;  // [RL3] [RL4]

    // ****************************************************************
    // Setpoint registers and classification.
    // ****************************************************************
    logic [31:0]       sp_q [4];
    logic [MEAS_W-1:0] sp_low;
    logic [MEAS_W-1:0] sp_low_appr;
    logic [MEAS_W-1:0] sp_high_appr;
    logic [MEAS_W-1:0] sp_high;
    class_type         present;

    assign sp_low       = sp_q[0][MEAS_W-1:0];
    assign sp_low_appr  = sp_q[1][MEAS_W-1:0];
    assign sp_high_appr = sp_q[2][MEAS_W-1:0];
    assign sp_high      = sp_q[3][MEAS_W-1:0];

    assign present = (MEASUREMENT >  sp_high)      ? CLS_OVER :
                     (MEASUREMENT >  sp_high_appr) ? CLS_OVER_APPR :
                     (MEASUREMENT >= sp_low_appr)  ? CLS_GOOD :
                     (MEASUREMENT >= sp_low)       ? CLS_UNDER_APPR : CLS_UNDER;  // [RL11]

    // ****************************************************************
    // Class state.
    // ****************************************************************
    class_type   extreme_q;
    class_type   extreme_d;
    class_type   latch_next;
    class_type   shown_q;
    class_type   shown_d;
    logic        active_q;
    logic        active_d;

    assign latch_next = (distance(present) > distance(extreme_q)) ? present : extreme_q;  // [RL8]
    assign extreme_d  = (mode == MODE_LATCH) ? latch_next :
                        (mode == MODE_HOLD)  ? extreme_q : CLS_GOOD;  // [RL6] [RL8]
    assign shown_d    = (mode == MODE_FOLLOW) ? present :
                        (mode == MODE_LATCH)  ? latch_next :
                        (mode == MODE_HOLD)   ? shown_q : CLS_GOOD;  // [RL7] [RL9]
    assign active_d   = (mode == MODE_HOLD) ? active_q : (mode != MODE_RESET);  // [RL6] [RL9]

    logic [2:0] code_d;
    logic [4:0] lamps_d;

    assign code_d  = active_d ? class_code(shown_d) : 3'h0;  // [RL12]
    assign lamps_d = active_d ? 5'(5'h01 << shown_d) : 5'h00;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            extreme_q   <= CLS_GOOD;
            shown_q     <= CLS_GOOD;
            active_q    <= 1'b0;
            LIMIT_LAMPS <= 5'h00;
            {OVER_CLASS_OUTPUT, GOOD_CLASS_OUTPUT, UNDER_CLASS_OUTPUT} <= 3'h0;
        end else begin
            extreme_q   <= extreme_d;
            shown_q     <= shown_d;
            active_q    <= active_d;
            LIMIT_LAMPS <= lamps_d;
            {OVER_CLASS_OUTPUT, GOOD_CLASS_OUTPUT, UNDER_CLASS_OUTPUT} <= code_d;
        end
    end

    // ****************************************************************
    // Display path.
    // ****************************************************************
    logic [MEAS_W-1:0] display_d;

    assign display_d = is_cal ? sp_q[sel_pos[1:0]][MEAS_W-1:0] : MEASUREMENT;  // [RL2]

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            DISPLAY_VALUE <= '0;
        end else begin
            DISPLAY_VALUE <= display_d;
        end
    end

    // ****************************************************************
    // Wishbone slave.
    // ****************************************************************
    logic        req;
    logic        wr_sp;
    logic [31:0] status;
    logic [31:0] rd_d;

    // A constant table keeps the asynchronous reset branch free of anything but literals.
    localparam logic [31:0] sp_rst [4] = '{`RST_SP_LOW, `RST_SP_LOW_APPR, `RST_SP_HIGH_APPR, `RST_SP_HIGH};

    // Answer one cycle after the request; WB_ACK_O keeps a held request from being taken twice.
    assign req   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr_sp = req && WB_WE_I && (WB_ADR_I[1:0] == 2'h0) && (WB_ADR_I < `OFS_STATUS);

    assign status = (32'(present)  << `ST_PRESENT_LSB) |
                    (32'(shown_q)  << `ST_SHOWN_LSB) |
                    (32'(active_q) << `ST_ACTIVE_BIT) |
                    (32'(mode)     << `ST_MODE_LSB) |
                    (32'(sel_pos)  << `ST_SELECT_LSB);

    // Only the setpoint width is stored, so wider write data reads back truncated.
    assign rd_d = (WB_ADR_I == `OFS_SP_LOW)       ? sp_q[0] :
                  (WB_ADR_I == `OFS_SP_LOW_APPR)  ? sp_q[1] :
                  (WB_ADR_I == `OFS_SP_HIGH_APPR) ? sp_q[2] :
                  (WB_ADR_I == `OFS_SP_HIGH)      ? sp_q[3] :
                  (WB_ADR_I == `OFS_STATUS)       ? status : 32'h0000_0000;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sp
            logic [31:0] merged;
            assign merged = merge(sp_q[gi], WB_DAT_I, WB_SEL_I) & 32'((33'h1 << MEAS_W) - 33'h1);
            always_ff @(posedge CLK_SYS or negedge RST_N) begin
                if (!RST_N) begin
                    sp_q[gi] <= sp_rst[gi];
                end else if (wr_sp && (WB_ADR_I[3:2] == 2'(gi))) begin
                    sp_q[gi] <= merged;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= req;
            WB_DAT_O <= (req && !WB_WE_I) ? rd_d : 32'h0000_0000;
        end
    end

endmodule // five_class_limit

// *** five_class_limit_sva.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Port checker.
// ****************************************************************
module five_class_limit_chk (
    // Clock, reset and bus.
    input wire logic        CLK_SYS,
    input wire logic        RST_N,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    // Controls and outputs.
    input wire logic [2:0]  SELECTOR,
    input wire logic        FREEZE_COMMAND_LINE,
    input wire logic        CLEAR_COMMAND_LINE,
    input wire logic [4:0]  LIMIT_LAMPS,
    input wire logic        OVER_CLASS_OUTPUT,
    input wire logic        GOOD_CLASS_OUTPUT,
    input wire logic        UNDER_CLASS_OUTPUT
);
    logic [2:0] outs;
    logic [2:0] lamp_code;
    logic       auto_run;
    assign outs = {OVER_CLASS_OUTPUT, GOOD_CLASS_OUTPUT, UNDER_CLASS_OUTPUT};
    assign auto_run = SELECTOR == 3'h5;
    assign lamp_code = LIMIT_LAMPS[0] ? 3'h1 : LIMIT_LAMPS[1] ? 3'h3 : LIMIT_LAMPS[2] ? 3'h2 :
                       LIMIT_LAMPS[3] ? 3'h6 : LIMIT_LAMPS[4] ? 3'h4 : 3'h0;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    a_code_from_lamps: assert property ((LIMIT_LAMPS == 5'h0 || $onehot(LIMIT_LAMPS)) && outs == lamp_code)
        else $error("class outputs disagree with lamps");
    a_ack_follows_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus request not acknowledged");
    a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("acknowledge longer than one cycle");
    a_ack_has_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_STB_I))
        else $error("acknowledge without request");
    a_data_idle_zero: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data outside acknowledge");
    a_manual_lit: assert property ((SELECTOR == 3'h4) [*3] |=> $onehot(LIMIT_LAMPS))
        else $error("manual run not showing a class");
    a_reset_blanks: assert property ((auto_run && FREEZE_COMMAND_LINE && !CLEAR_COMMAND_LINE) [*3]
        |=> LIMIT_LAMPS == 5'h0 && outs == 3'h0) else $error("reset mode not blank");
    a_hold_freezes: assert property ((auto_run && FREEZE_COMMAND_LINE && CLEAR_COMMAND_LINE) [*3]
        |=> $stable(LIMIT_LAMPS) && $stable(outs)) else $error("hold mode changed outputs");
    // Five cycles so that stale follow output has left the register first.
    a_latch_keeps_far: assert property ((auto_run && !FREEZE_COMMAND_LINE && CLEAR_COMMAND_LINE) [*5]
        |-> !($past(LIMIT_LAMPS) inside {5'h01, 5'h10}) || $stable(LIMIT_LAMPS))
        else $error("latch lost an extreme class");
endmodule // five_class_limit_chk

bind five_class_limit five_class_limit_chk u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SELECTOR(SELECTOR),
    .FREEZE_COMMAND_LINE(FREEZE_COMMAND_LINE), .CLEAR_COMMAND_LINE(CLEAR_COMMAND_LINE),
    .LIMIT_LAMPS(LIMIT_LAMPS), .OVER_CLASS_OUTPUT(OVER_CLASS_OUTPUT), .GOOD_CLASS_OUTPUT(GOOD_CLASS_OUTPUT),
    .UNDER_CLASS_OUTPUT(UNDER_CLASS_OUTPUT));

// *** remote_controller.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Rear command line controller.
// ****************************************************************
module remote_controller (
    // Clock and reset.
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    // Requested mode and command lines.
    input  wire five_class_pkg::mode_type mode_req,
    output logic                          freeze_line,
    output logic                          clear_line
);
    import five_class_pkg::*;
    // Lines move only after an edge; the controller cannot know the selector.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            freeze_line <= 1'b0;
            clear_line  <= 1'b0;
        end else begin
            freeze_line <= mode_req inside {MODE_HOLD, MODE_RESET};
            clear_line  <= mode_req inside {MODE_LATCH, MODE_HOLD};
        end
    end
endmodule // remote_controller

// *** tb_five_class_limit.sv ***
`timescale 1ns/10ps
`include "five_class_cfg.svh"
module tb_five_class_limit;
    import five_class_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat_w = 32'h0;
    logic [3:0]  be = 4'hF;
    logic [31:0] dat_r;
    logic [31:0] rd;
    logic        ack;
    logic [2:0]  sel = 3'h4;
    logic        freeze;
    logic        clear;
    logic [15:0] meas = 16'h0;
    logic [15:0] disp;
    logic [4:0]  lamps;
    logic [2:0]  outs;
    mode_type    mode_req = MODE_FOLLOW;
    int          errors = 0;
    int          compares = 0;
    int          store = 2;
    int          shown = 2;
    int          sp [4] = '{`RST_SP_LOW, `RST_SP_LOW_APPR, `RST_SP_HIGH_APPR, `RST_SP_HIGH};
    logic [2:0]  tbl [5] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
    mode_type    seq_m [14] = '{MODE_FOLLOW, MODE_LATCH, MODE_LATCH, MODE_LATCH, MODE_LATCH, MODE_LATCH,
        MODE_LATCH, MODE_HOLD, MODE_HOLD, MODE_LATCH, MODE_FOLLOW, MODE_RESET, MODE_HOLD, MODE_FOLLOW};
    logic [15:0] seq_v [14] = '{16'h4000, 16'h4000, 16'h2000, 16'h4000, 16'h7000, 16'h8000, 16'h0800,
        16'h4000, 16'h0800, 16'h4000, 16'h7000, 16'h8000, 16'h4000, 16'h0800};
    always #20 clk_sys = ~clk_sys;
    five_class_limit DUT (.CLK_SYS(clk_sys), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(be), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
        .SELECTOR(sel), .FREEZE_COMMAND_LINE(freeze), .CLEAR_COMMAND_LINE(clear), .MEASUREMENT(meas),
        .DISPLAY_VALUE(disp), .LIMIT_LAMPS(lamps), .OVER_CLASS_OUTPUT(outs[2]),
        .GOOD_CLASS_OUTPUT(outs[1]), .UNDER_CLASS_OUTPUT(outs[0]));
    remote_controller u_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .mode_req(mode_req),
        .freeze_line(freeze), .clear_line(clear));
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_cls(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        be <= s;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            errors++;
            stop_test();
        end
    endtask
    function automatic int cls_of(int m);
        int c = 0;
        for (int i = 0; i < 4; i++) if (m >= sp[i] + (i >= 2)) c = i + 1;
        return c;
    endfunction
    // Model of the outputs once the lines have crossed the synchroniser.
    task automatic check_out(input string name);
        int       c;
        mode_type m;
        repeat (6) @(posedge clk_sys);
        #1;
        c = cls_of(meas);
        m = (sel == SEL_AUTO_RUN) ? mode_req : MODE_FOLLOW;
        if (m == MODE_FOLLOW) store = 2;
        if (m == MODE_LATCH && (c - 2) * (c - 2) > (store - 2) * (store - 2)) store = c;
        if (m == MODE_RESET) store = 2;
        if (m != MODE_HOLD) shown = (m == MODE_RESET) ? -1 : (m == MODE_LATCH) ? store : c;
        chk_cls(name, (shown < 0) ? 8'h00 : {5'(1 << shown), tbl[shown]}, {lamps, outs});
        if (sel > 3'h3) chk_reg("display", 32'(meas), {16'h0, disp});
    endtask
    initial begin
        void'($urandom(32'h10143BF3));
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, 8'(4 * i), 32'h0, 4'hF);
            chk_reg("setpoint", 32'(sp[i]), rd);
        end
        wb(1'b0, 8'h14, 32'h0, 4'hF);
        chk_reg("unmapped", 32'h0, rd);
        sp[2] = 32'h3001 + $urandom % 32'h3FFE;
        wb(1'b1, `OFS_SP_HIGH_APPR, 32'(sp[2]), 4'hF);
        wb(1'b0, `OFS_SP_HIGH_APPR, 32'h0, 4'hF);
        chk_reg("setpoint", 32'(sp[2]), rd);
        // Byte lane 1 is masked off and the upper half lies beyond the setpoint width.
        wb(1'b1, `OFS_SP_LOW, 32'hABCD_12C5, 4'hD);
        wb(1'b0, `OFS_SP_LOW, 32'h0, 4'hF);
        sp[0] = 32'h10C5;
        chk_reg("setpoint", 32'(sp[0]), rd);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            sel <= 3'(i);
            check_out("cal");
            chk_reg("display", 32'(sp[i]), {16'h0, disp});
        end
        @(posedge clk_sys);
        sel <= SEL_MANUAL_RUN;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            meas <= 16'($urandom);
            sel <= (i >= 12) ? 3'(6 + (i % 2)) : 3'h4;
            mode_req <= mode_type'($urandom % 4);
            check_out("manual");
        end
        @(posedge clk_sys);
        sel <= SEL_AUTO_RUN;
        for (int i = 0; i < 14; i++) begin
            @(posedge clk_sys);
            meas <= seq_v[i];
            mode_req <= seq_m[i];
            check_out("auto");
        end
        wb(1'b0, `OFS_STATUS, 32'h0, 4'hF);
        chk_reg("status", (32'h5 << `ST_SELECT_LSB) | (32'h1 << `ST_ACTIVE_BIT) | (32'(shown) << `ST_SHOWN_LSB)
            | (32'(cls_of(meas)) << `ST_PRESENT_LSB), rd);
        stop_test();
    end
endmodule // tb_five_class_limit
